// ===== perf_monitor_counters.sv
// performance monitor: control registers, four counters, interrupt
//
// Summary of operation
// - user view mirrors control register 0
// - counter 3 selector in top five bits
// - counter 4 selector bits 5-9, rest reserved
// - control register 1 read/write at 956
// - user view of register 1 at 940
// - four 32-bit counters, overflow can interrupt
// - top bit is the overflow flag
// - lower bits count selected events
// - overflow once value reaches 2147483648
// - overflow interrupt needs counter gate and global gate
// - exception waits for external mask bit
// - freeze option stops counters on interrupt
// - overflowed load may interrupt without events
// - count while control set, until interrupt if freeze set
// - codes hold, cycles, completed instructions
// - code 3 counts chosen time-base rises
// - dispatch count, barriers, table search cycles
// - L2 hits, fetch addresses, breakpoint matches
// - long load misses, unresolved branches, stalls
// - counter 2 uses same thirteen codes
// - reserved codes have no defined counting
// - counter 1 selector at bits 19-25
// - counter 2 selector at bits 26-31
// - hardware clears global gate on interrupt
// - six-bit latency threshold in register 0
`timescale 1ns/10ps
module perf_monitor_counters (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // special register moves
  input  wire logic [9:0]  spr_num_i,
  input  wire logic        spr_wr_i,
  input  wire logic        spr_rd_i,
  input  wire logic [31:0] spr_wdata_i,
  output logic      [31:0] spr_rdata_o,
  output logic             spr_ack_o,
  // exception path
  input  wire logic        external_irq_mask_bit_i,
  input  wire logic        exc_ack_i,
  output logic             irq_o,
  // pipeline and cache events
  input  wire logic        instr_done_i,
  input  wire logic [1:0]  disp_cnt_i,
  input  wire logic [31:0] tbl_i,
  input  wire logic        barrier_done_i,
  input  wire logic        instr_translation_buffer_search_i,
  input  wire logic        l2_hit_i,
  input  wire logic        fetch_ea_i,
  input  wire logic        bkpt_match_i,
  input  wire logic        ld_miss_done_i,
  input  wire logic [7:0]  ld_miss_lat_i,
  input  wire logic        br_unres_i,
  input  wire logic        disp_stall_i,
  input  wire logic [31:0] c3_ev_i,
  input  wire logic [31:0] c4_ev_i
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] monitor_control_0_q;
  logic [31:0] monitor_control_1_q;
  logic        frozen_q;
  logic        pend_q;
  logic        pend_d;
  logic [31:0] tb_prev_q;
  logic [31:0] rd_d;
  logic        hit_d;
  logic [31:0] cnt     [4];
  logic [9:0]  cnt_spr [4];
  logic [6:0]  sel     [4];
  logic [31:0] vec     [4];
  logic        en      [4];
  logic [1:0]  inc     [4];

  //////////////////////////////////////////////////////////////////////////////
  // field decode
  logic        global_irq_gate;
  logic        freeze_on_irq;
  logic [1:0]  timebase_bit_sel;
  logic        tb_irq_en;
  logic [5:0]  ld_threshold;
  logic        counter1_irq_gate;
  logic        counter_irq_gate;
  logic        trig_hold;
  logic        wr_ctl0;
  logic        wr_ctl1;
  logic [4:0]  tb_pos;
  logic        tb_bit;
  logic        tb_edge;
  logic        ld_long;
  logic        win_en;
  logic        irq_evt;

  assign global_irq_gate   = monitor_control_0_q[perf_mon_pkg::GIRQ_BIT];
  assign freeze_on_irq     = monitor_control_0_q[perf_mon_pkg::FREEZE_BIT];
  assign timebase_bit_sel  = monitor_control_0_q[perf_mon_pkg::TBSEL_LSB +: 2];
  assign tb_irq_en         = monitor_control_0_q[perf_mon_pkg::TBIRQ_BIT];
  assign ld_threshold      = monitor_control_0_q[perf_mon_pkg::THR_LSB +: 6];
  assign counter1_irq_gate = monitor_control_0_q[perf_mon_pkg::C1GATE_BIT];
  assign counter_irq_gate  = monitor_control_0_q[perf_mon_pkg::CGATE_BIT];
  assign trig_hold         = monitor_control_0_q[perf_mon_pkg::TRIG_BIT];

  assign wr_ctl0 = spr_wr_i && (spr_num_i == perf_mon_pkg::SPR_CTL0);
  assign wr_ctl1 = spr_wr_i && (spr_num_i == perf_mon_pkg::SPR_CTL1);

  //////////////////////////////////////////////////////////////////////////////
  // control registers; the user views have no write path at all
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      monitor_control_0_q <= perf_mon_pkg::CTL0_RST;
    end else if (wr_ctl0) begin
      // a software write wins so a re-armed gate is never lost
      monitor_control_0_q <= spr_wdata_i;
    end else if (irq_evt) begin
      monitor_control_0_q[perf_mon_pkg::GIRQ_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      monitor_control_1_q <= perf_mon_pkg::CTL1_RST;
    end else if (wr_ctl1) begin
      monitor_control_1_q <= spr_wdata_i & perf_mon_pkg::CTL1_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // time base bit edge; the time base runs on this clock, so no synchroniser
  always_comb begin
    unique case (timebase_bit_sel)
      2'h0:    tb_pos = perf_mon_pkg::TB_POS_0;
      2'h1:    tb_pos = perf_mon_pkg::TB_POS_1;
      2'h2:    tb_pos = perf_mon_pkg::TB_POS_2;
      default: tb_pos = perf_mon_pkg::TB_POS_3;
    endcase
  end

  // the whole word is kept so a fresh bit choice compares with its own past value
  assign tb_bit  = tbl_i[5'h1F - tb_pos];
  assign tb_edge = tb_bit && !tb_prev_q[5'h1F - tb_pos];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tb_prev_q <= 32'h0000_0000;
    end else begin
      tb_prev_q <= tbl_i;
    end
  end

  assign ld_long = ld_miss_done_i && (ld_miss_lat_i > {2'h0, ld_threshold});

  //////////////////////////////////////////////////////////////////////////////
  // event selection per counter
  assign sel[0] = monitor_control_0_q[perf_mon_pkg::SEL1_LSB +: 7];
  assign sel[1] = {1'b0, monitor_control_0_q[perf_mon_pkg::SEL2_LSB +: 6]};
  assign sel[2] = {2'h0, monitor_control_1_q[perf_mon_pkg::SEL3_LSB +: 5]};
  assign sel[3] = {2'h0, monitor_control_1_q[perf_mon_pkg::SEL4_LSB +: 5]};

  // bit n of a vector is the event for code n; codes 0, 3, 4 are decoded apart
  assign vec[0] = {19'h0, disp_stall_i, br_unres_i, ld_long, bkpt_match_i,
                   fetch_ea_i, l2_hit_i, instr_translation_buffer_search_i, barrier_done_i,
                   2'h0, instr_done_i, 1'b1, 1'b0};
  assign vec[1] = vec[0];
  assign vec[2] = {c3_ev_i[31:3], instr_done_i, 2'b10};
  assign vec[3] = {c4_ev_i[31:3], instr_done_i, 2'b10};

  assign cnt_spr[0] = perf_mon_pkg::SPR_CNT1;
  assign cnt_spr[1] = perf_mon_pkg::SPR_CNT2;
  assign cnt_spr[2] = perf_mon_pkg::SPR_CNT3;
  assign cnt_spr[3] = perf_mon_pkg::SPR_CNT4;

  // counting runs while register 0 is set up and no freeze is in force
  assign win_en = (monitor_control_0_q != 32'h0) && !frozen_q;
  assign en[0]  = win_en;
  assign en[1]  = win_en && (!trig_hold || cnt[0][perf_mon_pkg::OVF_BIT] || pend_q);
  assign en[2]  = en[1];
  assign en[3]  = en[1];

  for (genvar i = 0; i < 4; i++) begin : g_cnt
    perf_event_select u_sel (
      .sel_i      (sel[i]),
      .vec_i      (vec[i]),
      .tb_edge_i  (tb_edge),
      .disp_cnt_i (disp_cnt_i),
      .inc_o      (inc[i])
    );
    perf_counter u_cnt (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .load_i     (spr_wr_i && (spr_num_i == cnt_spr[i])),
      .load_val_i (spr_wdata_i),
      .en_i       (en[i]),
      .inc_i      (inc[i]),
      .cnt_o      (cnt[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt: overflow is the top bit, so a loaded 0x8000_0000 also fires
  assign irq_evt = global_irq_gate &&
                   ((counter1_irq_gate && cnt[0][perf_mon_pkg::OVF_BIT]) ||
                    (counter_irq_gate && (cnt[1][perf_mon_pkg::OVF_BIT] ||
                                          cnt[2][perf_mon_pkg::OVF_BIT] ||
                                          cnt[3][perf_mon_pkg::OVF_BIT])) ||
                    (tb_irq_en && tb_edge));

  // set wins over the exception acknowledge
  assign pend_d = irq_evt || (pend_q && !exc_ack_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // the condition may stand with the mask clear; only delivery waits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= pend_d && external_irq_mask_bit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frozen_q <= 1'b0;
    end else if (irq_evt && freeze_on_irq) begin
      frozen_q <= 1'b1;
    end else if (wr_ctl0) begin
      frozen_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads, answered one cycle later
  always_comb begin
    rd_d  = 32'h0;
    hit_d = 1'b1;
    unique case (spr_num_i)
      perf_mon_pkg::SPR_CTL0,
      perf_mon_pkg::SPR_UCTL0: rd_d = monitor_control_0_q;
      perf_mon_pkg::SPR_CTL1,
      perf_mon_pkg::SPR_UCTL1: rd_d = monitor_control_1_q;
      perf_mon_pkg::SPR_CNT1:  rd_d = cnt[0];
      perf_mon_pkg::SPR_CNT2:  rd_d = cnt[1];
      perf_mon_pkg::SPR_CNT3:  rd_d = cnt[2];
      perf_mon_pkg::SPR_CNT4:  rd_d = cnt[3];
      default:                 hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      spr_rdata_o <= 32'h0;
      spr_ack_o   <= 1'b0;
    end else begin
      spr_rdata_o <= spr_rd_i ? rd_d : 32'h0;
      spr_ack_o   <= (spr_rd_i || spr_wr_i) && hit_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ovf_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    (global_irq_gate && counter1_irq_gate && cnt[0][31]) |=> pend_q;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow missed");

  property p_no_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(pend_q) |-> $past(global_irq_gate);
  endproperty
  a_no_gate: assert property (p_no_gate) else $error("ungated irq");

  property p_defer;
    @(posedge clk_i) disable iff (!rst_n_i)
    !external_irq_mask_bit_i |=> !irq_o;
  endproperty
  a_defer: assert property (p_defer) else $error("irq while masked");

  property p_take;
    @(posedge clk_i) disable iff (!rst_n_i)
    (pend_q && !exc_ack_i && external_irq_mask_bit_i) |=> irq_o;
  endproperty
  a_take: assert property (p_take) else $error("pending irq lost");

  property p_gate_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (irq_evt && !wr_ctl0) |=> !global_irq_gate;
  endproperty
  a_gate_clr: assert property (p_gate_clr) else $error("gate not cleared");

  property p_freeze;
    @(posedge clk_i) disable iff (!rst_n_i)
    (irq_evt && freeze_on_irq && !spr_wr_i) ##1 !spr_wr_i |=> $stable(cnt[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counted while frozen");

  property p_cycles;
    @(posedge clk_i) disable iff (!rst_n_i)
    (sel[0] == perf_mon_pkg::EV_CYCLE && win_en && !spr_wr_i)
      |=> cnt[0] == $past(cnt[0]) + 32'h1;
  endproperty
  a_cycles: assert property (p_cycles) else $error("cycle count wrong");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (sel[0] == perf_mon_pkg::EV_HOLD && !spr_wr_i) |=> $stable(cnt[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("hold code counted");

  property p_view_ro;
    @(posedge clk_i) disable iff (!rst_n_i)
    (spr_wr_i && spr_num_i == perf_mon_pkg::SPR_UCTL1)
      |=> $stable(monitor_control_1_q);
  endproperty
  a_view_ro: assert property (p_view_ro) else $error("user view written");

  property p_view_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (spr_rd_i && !spr_wr_i && spr_num_i == perf_mon_pkg::SPR_UCTL1)
      |=> spr_ack_o && spr_rdata_o == monitor_control_1_q;
  endproperty
  a_view_rd: assert property (p_view_rd) else $error("user view read bad");

  property p_tb_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
    (sel[0] == perf_mon_pkg::EV_TB && win_en && !spr_wr_i && $stable(monitor_control_0_q))
      |=> cnt[0] == $past(cnt[0]) + {31'h0, $past(tb_bit) && !$past(tb_bit, 2)};
  endproperty
  a_tb_rise: assert property (p_tb_rise) else $error("time base count wrong");

  c_irq:    cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
  c_frozen: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(frozen_q));
  c_ovf:    cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(cnt[0][31]));
endmodule

// ===== perf_mon_pkg.sv
// constants for the performance monitor counter block
package perf_mon_pkg;
  // special register numbers
  localparam logic [9:0] SPR_UCTL0 = 10'h3A8;
  localparam logic [9:0] SPR_UCTL1 = 10'h3AC;
  localparam logic [9:0] SPR_CTL0  = 10'h3B8;
  localparam logic [9:0] SPR_CNT1  = 10'h3B9;
  localparam logic [9:0] SPR_CNT2  = 10'h3BA;
  localparam logic [9:0] SPR_CTL1  = 10'h3BC;
  localparam logic [9:0] SPR_CNT3  = 10'h3BD;
  localparam logic [9:0] SPR_CNT4  = 10'h3BE;
  //////////////////////////////////////////////////////////////////////////////
  // control register 0 fields (lsb positions, msb-first bit 0 is bit 31)
  localparam int GIRQ_BIT   = 26;
  localparam int FREEZE_BIT = 25;
  localparam int TBSEL_LSB  = 23;
  localparam int TBIRQ_BIT  = 22;
  localparam int THR_LSB    = 16;
  localparam int C1GATE_BIT = 15;
  localparam int CGATE_BIT  = 14;
  localparam int TRIG_BIT   = 13;
  localparam int SEL1_LSB   = 6;
  localparam int SEL2_LSB   = 0;
  // control register 1 fields
  localparam int SEL3_LSB   = 27;
  localparam int SEL4_LSB   = 22;
  localparam logic [31:0] CTL1_MASK = 32'hFFC0_0000;
  // counter fields
  localparam int OVF_BIT    = 31;
  // reset values
  localparam logic [31:0] CTL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTL1_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;
  //////////////////////////////////////////////////////////////////////////////
  // event select codes shared by all counters
  localparam logic [6:0] EV_HOLD    = 7'h00;
  localparam logic [6:0] EV_CYCLE   = 7'h01;
  localparam logic [6:0] EV_DONE    = 7'h02;
  localparam logic [6:0] EV_TB      = 7'h03;
  localparam logic [6:0] EV_DISP    = 7'h04;
  // counter 1 and 2 only
  localparam logic [6:0] EV_BARRIER = 7'h05;
  localparam logic [6:0] EV_INSTR_TRANSLATION_BUFFER    = 7'h06;
  localparam logic [6:0] EV_L2HIT   = 7'h07;
  localparam logic [6:0] EV_FETCH   = 7'h08;
  localparam logic [6:0] EV_BKPT    = 7'h09;
  localparam logic [6:0] EV_LDMISS  = 7'h0A;
  localparam logic [6:0] EV_BRUNRES = 7'h0B;
  localparam logic [6:0] EV_STALL   = 7'h0C;
  // time base bit chosen per selector value, msb-first numbering
  localparam logic [4:0] TB_POS_0 = 5'h0F;
  localparam logic [4:0] TB_POS_1 = 5'h13;
  localparam logic [4:0] TB_POS_2 = 5'h17;
  localparam logic [4:0] TB_POS_3 = 5'h1F;
endpackage

// ===== perf_event_select.sv
// per-counter event selector: turns a select code into an increment
`timescale 1ns/10ps
module perf_event_select (
  // selection
  input  wire logic [6:0]  sel_i,
  input  wire logic [31:0] vec_i,
  // shared sources
  input  wire logic        tb_edge_i,
  input  wire logic [1:0]  disp_cnt_i,
  // increment
  output logic      [1:0]  inc_o
);
  always_comb begin
    inc_o = 2'h0;
    if (sel_i == perf_mon_pkg::EV_HOLD) begin
      inc_o = 2'h0;
    end else if (sel_i == perf_mon_pkg::EV_TB) begin
      inc_o = {1'b0, tb_edge_i};
    end else if (sel_i == perf_mon_pkg::EV_DISP) begin
      inc_o = disp_cnt_i;
    end else if (sel_i[6:5] == 2'h0) begin
      // reserved codes see a zero vector bit and hold
      inc_o = {1'b0, vec_i[sel_i[4:0]]};
    end
  end
endmodule

// ===== perf_counter.sv
// one 32-bit event counter with software load
`timescale 1ns/10ps
module perf_counter (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        load_i,
  input  wire logic [31:0] load_val_i,
  input  wire logic        en_i,
  input  wire logic [1:0]  inc_i,
  // value
  output logic      [31:0] cnt_o
);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_o <= perf_mon_pkg::CNT_RST;
    end else if (load_i) begin
      // a load wins over a count in the same cycle
      cnt_o <= load_val_i;
    end else if (en_i) begin
      cnt_o <= cnt_o + {30'h0, inc_i};
    end
  end
endmodule

// ===== perf_event_source.sv
// partner model: pipeline and cache event sources feeding the monitor
`timescale 1ns/10ps
module perf_event_source (
  // clock and run control
  input  wire logic        clk_i,
  input  wire logic        run_i,
  // event qualifiers: [0] done, [1..8] codes 5..12, [6] is the load miss
  output logic      [8:0]  flags_o,
  output logic      [1:0]  disp_cnt_o,
  output logic      [31:0] tbl_o,
  output logic      [7:0]  lat_o,
  output logic      [31:0] c3_o,
  output logic      [31:0] c4_o
);
  initial begin
    flags_o = 9'h000;
    disp_cnt_o = 2'h0;
    tbl_o = 32'h0000_0000;
    lat_o = 8'h00;
    c3_o = 32'h0000_0000;
    c4_o = 32'h0000_0000;
  end
  // time base holds while idle so no stray rises reach the counters
  always @(negedge clk_i) begin
    if (run_i) begin
      flags_o <= 9'($urandom);
      disp_cnt_o <= 2'($urandom_range(2));
      tbl_o <= $urandom;
      lat_o <= 8'($urandom_range(127));
      c3_o <= $urandom;
      c4_o <= $urandom;
    end else begin
      flags_o <= 9'h000;
      disp_cnt_o <= 2'h0;
      c3_o <= 32'h0000_0000;
      c4_o <= 32'h0000_0000;
    end
  end
endmodule

// ===== perf_monitor_counters_tb.sv
// self-checking bench for the performance monitor counter block
`timescale 1ns/10ps
module perf_monitor_counters_tb;
  logic        clk_i;
  logic        rst_n_i;
  logic [9:0]  spr_num_i;
  logic        spr_wr_i;
  logic        spr_rd_i;
  logic [31:0] spr_wdata_i;
  logic [31:0] spr_rdata_o;
  logic        spr_ack_o;
  logic        mask;
  logic        exc_ack;
  logic        irq_o;
  logic        run;
  logic [8:0]  flags;
  logic [1:0]  disp_cnt;
  logic [31:0] tbl;
  logic [7:0]  lat;
  logic [31:0] c3_ev;
  logic [31:0] c4_ev;
  logic [31:0] m_ctl0;
  logic [31:0] m_ctl1;
  logic [31:0] prev_tbl;
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] m_cnt [1:4];
  logic [9:0]  nums [8] = '{10'h3A8, 10'h3AC, 10'h3B8, 10'h3B9,
                            10'h3BA, 10'h3BC, 10'h3BD, 10'h3BE};
  int          tbpos [4] = '{15, 19, 23, 31};
  int          n_fail;
  int          comparisons;
  //////////////////////////////////////////////////////////////////////////////
  perf_monitor_counters DUT (
    .clk_i                   (clk_i),
    .rst_n_i                 (rst_n_i),
    .spr_num_i               (spr_num_i),
    .spr_wr_i                (spr_wr_i),
    .spr_rd_i                (spr_rd_i),
    .spr_wdata_i             (spr_wdata_i),
    .spr_rdata_o             (spr_rdata_o),
    .spr_ack_o               (spr_ack_o),
    .external_irq_mask_bit_i (mask),
    .exc_ack_i               (exc_ack),
    .irq_o                   (irq_o),
    .instr_done_i            (flags[0]),
    .disp_cnt_i              (disp_cnt),
    .tbl_i                   (tbl),
    .barrier_done_i          (flags[1]),
    .instr_translation_buffer_search_i           (flags[2]),
    .l2_hit_i                (flags[3]),
    .fetch_ea_i              (flags[4]),
    .bkpt_match_i            (flags[5]),
    .ld_miss_done_i          (flags[6]),
    .ld_miss_lat_i           (lat),
    .br_unres_i              (flags[7]),
    .disp_stall_i            (flags[8]),
    .c3_ev_i                 (c3_ev),
    .c4_ev_i                 (c4_ev)
  );
  perf_event_source partner (
    .clk_i      (clk_i),
    .run_i      (run),
    .flags_o    (flags),
    .disp_cnt_o (disp_cnt),
    .tbl_o      (tbl),
    .lat_o      (lat),
    .c3_o       (c3_ev),
    .c4_o       (c4_ev)
  );
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  // reference model: increment of counter k for this cycle's events
  function automatic logic [31:0] inc(input int k);
    logic [6:0] c;
    int         b;
    c = (k == 1) ? m_ctl0[12:6] : (k == 2) ? {1'b0, m_ctl0[5:0]} :
        (k == 3) ? {2'b00, m_ctl1[31:27]} : {2'b00, m_ctl1[26:22]};
    b = 31 - tbpos[m_ctl0[24:23]];
    case (c)
      7'h00: return 0;
      7'h01: return 1;
      7'h02: return flags[0];
      7'h03: return tbl[b] & ~prev_tbl[b];
      7'h04: return disp_cnt;
      default: begin
        if (k > 2) return (k == 3) ? c3_ev[c[4:0]] : c4_ev[c[4:0]];
        if (c == 7'h0A) return flags[6] && (lat > m_ctl0[21:16]);
        return flags[c - 7'h04];
      end
    endcase
  endfunction
  // counting while control 0 is non-zero; a load wins over the increment
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      m_ctl0 = 32'h0000_0000;
      m_ctl1 = 32'h0000_0000;
      prev_tbl = 32'h0000_0000;
      for (int k = 1; k < 5; k++) m_cnt[k] = 32'h0000_0000;
    end else begin
      for (int k = 1; k < 5; k++) if (m_ctl0 != 0) m_cnt[k] += inc(k);
      if (spr_wr_i && spr_num_i == perf_mon_pkg::SPR_CTL0) m_ctl0 = spr_wdata_i;
      if (spr_wr_i && spr_num_i == perf_mon_pkg::SPR_CTL1)
        m_ctl1 = spr_wdata_i & perf_mon_pkg::CTL1_MASK;
      for (int k = 0; k < 4; k++) if (spr_wr_i && spr_num_i == nums[k + 3 + k / 2])
        m_cnt[k + 1] = spr_wdata_i;
      prev_tbl = tbl;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  // one move: strobe for one cycle, answer looked at in the cycle after
  task automatic special_reg_number(input logic wr, input logic [9:0] num, input logic [31:0] wd,
                     input logic ack_exp);
    @(negedge clk_i);
    spr_num_i = num;
    spr_wr_i = wr;
    spr_rd_i = ~wr;
    spr_wdata_i = wd;
    @(negedge clk_i);
    spr_wr_i = 1'b0;
    spr_rd_i = 1'b0;
    rd = spr_rdata_o;
    chk("spr_ack_o", {31'h0, ack_exp}, {31'h0, spr_ack_o});
  endtask
  task automatic rdchk(input logic [9:0] num, input logic [31:0] exp);
    special_reg_number(1'b0, num, 32'h0000_0000, 1'b1);
    chk($sformatf("spr %h", num), exp, rd);
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq_o !== 1'b1; i++) @(negedge clk_i);
    chk("irq_o", 32'h0000_0001, {31'h0, irq_o});
    if (irq_o !== 1'b1) test_done();
  endtask
  task automatic take_exc();
    @(negedge clk_i);
    exc_ack = 1'b1;
    @(negedge clk_i);
    exc_ack = 1'b0;
    @(negedge clk_i);
    chk("irq_o", 32'h0000_0000, {31'h0, irq_o});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(63));
    rst_n_i = 1'b0;
    spr_num_i = 10'h000;
    spr_wr_i = 1'b0;
    spr_rd_i = 1'b0;
    spr_wdata_i = 32'h0000_0000;
    mask = 1'b1;
    exc_ack = 1'b0;
    run = 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (nums[i]) rdchk(nums[i], 32'h0000_0000);
    // control 1 keeps its selectors only; user views are read-only copies
    v = $urandom;
    special_reg_number(1'b1, nums[5], v, 1'b1);
    rdchk(nums[5], v & 32'hFFC0_0000);
    rdchk(nums[1], v & 32'hFFC0_0000);
    special_reg_number(1'b1, nums[1], ~v, 1'b1);
    rdchk(nums[5], v & 32'hFFC0_0000);
    v = $urandom & 32'h03BF_C000;
    special_reg_number(1'b1, nums[2], v, 1'b1);
    rdchk(nums[0], v);
    special_reg_number(1'b1, nums[0], ~v, 1'b1);
    rdchk(nums[2], v);
    special_reg_number(1'b0, 10'h3B0, 32'h0000_0000, 1'b0);
    chk("unmapped rdata", 32'h0000_0000, rd);
    // every defined select code on all four counters against the model
    for (int c = 0; c < 13; c++) begin
      for (int k = 0; k < 4; k++) begin
        special_reg_number(1'b1, nums[k+3+k/2], $urandom & 32'h00FF_FFFF, 1'b1);
      end
      special_reg_number(1'b1, nums[5], {c[4:0], c[4:0], 22'h00_0000}, 1'b1);
      v = ($urandom_range(3) << 23) | ($urandom_range(63) << 16) | (c << 6) | c;
      special_reg_number(1'b1, nums[2], v, 1'b1);
      run <= 1'b1;
      repeat (30 + $urandom_range(20)) @(negedge clk_i);
      run <= 1'b0;
      special_reg_number(1'b1, nums[2], 32'h0000_0000, 1'b1);
      for (int k = 0; k < 4; k++) begin
        rdchk(nums[k+3+k/2], m_cnt[k+1]);
      end
    end
    // overflow with freeze: interrupt, gate cleared, counter stops
    special_reg_number(1'b1, nums[3], 32'h7FFF_FFF0, 1'b1);
    v = 32'h0600_8000 | (32'h0000_0001 << 6);
    special_reg_number(1'b1, nums[2], v, 1'b1);
    wait_irq(40);
    rdchk(nums[2], 32'h0200_8040);
    special_reg_number(1'b0, nums[3], 32'h0000_0000, 1'b1);
    v = rd;
    chk("overflow flag", 32'h0000_0001, {31'h0, v[31]});
    repeat (3) @(negedge clk_i);
    rdchk(nums[3], v);
    take_exc();
    // overflowed load without the counter gate stays quiet
    special_reg_number(1'b1, nums[4], 32'h8000_0000, 1'b1);
    special_reg_number(1'b1, nums[2], 32'h0400_0000, 1'b1);
    repeat (4) @(negedge clk_i);
    chk("irq_o", 32'h0000_0000, {31'h0, irq_o});
    // masked: condition held pending until the mask bit is set
    mask = 1'b0;
    special_reg_number(1'b1, nums[2], 32'h0400_4000, 1'b1);
    repeat (4) @(negedge clk_i);
    chk("irq_o", 32'h0000_0000, {31'h0, irq_o});
    rdchk(nums[2], 32'h0000_4000);
    mask = 1'b1;
    wait_irq(3);
    take_exc();
    test_done();
  end
endmodule
